//--- include/llrm_pkg.sv
// constants and register map of the loop lock and reference loss monitor
package llrm_pkg;
   localparam int PD_W         = 24;
   localparam int OFS_W        = 14;
   localparam int THR_W        = 32;
   localparam int WD_W         = 16;
   localparam int XP_W         = 5;
   localparam int YP_W         = 3;
   localparam int DWELL_W      = 22;
   localparam logic [4:0] X_MAX = 5'h14;
   localparam int PIN_N        = 4;
   localparam int SEL_W        = 2;
   localparam logic [7:0] A_OFFSET   = 8'h00;
   localparam logic [7:0] A_PLK_THR  = 8'h04;
   localparam logic [7:0] A_FLK_THR  = 8'h08;
   localparam logic [7:0] A_PLK_DWL  = 8'h0C;
   localparam logic [7:0] A_FLK_DWL  = 8'h10;
   localparam logic [7:0] A_WD_A     = 8'h14;
   localparam logic [7:0] A_WD_B     = 8'h18;
   localparam logic [7:0] A_LOSS_CTL = 8'h1C;
   localparam logic [7:0] A_STATUS   = 8'h20;
   localparam logic [7:0] A_IRQ      = 8'h24;
   localparam int DWL_Y_LSB    = 8;
   localparam int CTL_EN_A     = 0;
   localparam int CTL_EN_B     = 1;
   localparam int CTL_SEL_LSB  = 8;
   localparam logic [WD_W-1:0] WD_RST = 16'hFFFF;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage : llrm_pkg

//--- logic/llrm_dwell.sv
// lock qualifier with power-of-two lock and unlock dwell counts
`timescale 1ns/1ps
module llrm_dwell #(
   parameter int CNT_W = llrm_pkg::DWELL_W
) (
   input  wire logic                      hclk,
   input  wire logic                      hresetn,
   input  wire logic                      tick,
   input  wire logic                      cmp_true,
   input  wire logic [llrm_pkg::XP_W-1:0] pow_x,
   input  wire logic [llrm_pkg::YP_W-1:0] pow_y,
   output      logic                      locked
);
   typedef struct packed {
      logic             lock;
      logic             last;
      logic [CNT_W-1:0] cnt;
   } llrm_dw_t;
   llrm_dw_t s_q;
   llrm_dw_t s_d;
   logic [CNT_W-1:0] run;
   logic [CNT_W-1:0] lk_target;
   logic [CNT_W-1:0] ul_target;
   always_comb begin
      s_d       = s_q;
      lk_target = CNT_W'(1) << ((pow_x > llrm_pkg::X_MAX) ? llrm_pkg::X_MAX : pow_x);
      ul_target = CNT_W'(2) << pow_y;
      run       = (cmp_true == s_q.last) ? s_q.cnt + CNT_W'(1) : CNT_W'(1);
      if (tick) begin
         s_d.last = cmp_true;
         s_d.cnt  = run;
         if (!s_q.lock && cmp_true && run >= lk_target) begin
            s_d.lock = 1'b1;
            s_d.cnt  = '0;
         end else if (s_q.lock && !cmp_true && run >= ul_target) begin
            s_d.lock = 1'b0;
            s_d.cnt  = '0;
         end else if (run == '1) begin
            s_d.cnt = s_q.cnt;
         end
      end
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
   assign locked = s_q.lock;
endmodule : llrm_dwell

//--- logic/llrm_top.sv
// loop lock detector, phase offset adder and reference loss watchdogs
// Summary of operation
// - add offset constant to every detector sample taken with pd_valid
// - offset is 14-bit signed two's complement
// - phase comparator true when magnitude within threshold
// - phase threshold is 32-bit writable unsigned
// - lock holds until unlock or reset
// - X is 5-bit field, 0 to 20
// - unlock after 2^(Y+1) consecutive false ticks
// - unlock clears lock, qualification restarts automatically
// - Y is 3-bit field, 0 to 7
// - frequency compare uses successive sample difference
// - frequency dwell uses its own register
// - per-reference enabled loss monitor, status and irq
// - selectable routing of loss flags to pins
// - watchdog restarts on reference rising edge
// - 16-bit terminal count per watchdog
// - watchdog advances every two system clocks
`timescale 1ns/1ps
module llrm_top #(
   parameter int PD_W = llrm_pkg::PD_W
) (
   input  wire logic                               hclk,
   input  wire logic                               hresetn,
   input  wire logic                               hsel,
   input  wire logic [7:0]                         haddr,
   input  wire logic [1:0]                         htrans,
   input  wire logic                               hwrite,
   input  wire logic [2:0]                         hsize,
   input  wire logic [31:0]                        hwdata,
   input  wire logic                               hready,
   output      logic [31:0]                        hrdata,
   output      logic                               hreadyout,
   output      logic                               hresp,
   input  wire logic                               loop_tick,
   input  wire logic                               pd_valid,
   input  wire logic signed [PD_W-1:0]             pd_sample,
   input  wire logic                               input_ref_a,
   input  wire logic                               input_ref_b,
   output      logic signed [PD_W-1:0]             pd_adjusted,
   output      logic                               phase_locked,
   output      logic                               freq_locked,
   output      logic [llrm_pkg::PIN_N-1:0]         status_pin_group
);
   localparam int PW = PD_W + 1;
   localparam int DW = llrm_pkg::DWL_Y_LSB + llrm_pkg::YP_W;
   typedef struct packed {
      logic                           wr_pend;
      logic [7:0]                     wr_addr;
      logic [llrm_pkg::OFS_W-1:0]     phase_offset_constant;
      logic [llrm_pkg::THR_W-1:0]     phase_lock_threshold;
      logic [llrm_pkg::THR_W-1:0]     freq_lock_threshold;
      logic [DW-1:0]                  plk_dwell;
      logic [DW-1:0]                  flk_dwell;
      logic [llrm_pkg::WD_W-1:0]      wd_cnt_a;
      logic [llrm_pkg::WD_W-1:0]      wd_cnt_b;
      logic [1:0]                     loss_en;
      logic [llrm_pkg::PIN_N*llrm_pkg::SEL_W-1:0] pin_sel;
      logic [1:0]                     irq_q;
      logic [31:0]                    rdata;
      logic signed [PD_W-1:0]         adj;
      logic                           ph_ok;
      logic                           fr_ok;
      logic                           half;
      logic [1:0]                     ref_last;
      logic [2*llrm_pkg::WD_W-1:0]    wd;
      logic [1:0]                     loss;
      logic [llrm_pkg::PIN_N-1:0]     pins;
   } llrm_st_t;
   llrm_st_t s_q;
   llrm_st_t s_d;
   logic signed [PD_W-1:0] adj_new;
   logic signed [PW-1:0]   diff;
   logic [PW-1:0]          mag_p;
   logic [PW-1:0]          mag_f;
   logic                   ph_lock;
   logic                   fr_lock;
   logic                   rd_take;
   logic                   wr_take;
   logic [1:0]             ref_now;
   logic [DW-1:0]          dwell_wr;
   logic [llrm_pkg::WD_W-1:0] wd_term [2];
   always_comb begin
      s_d     = s_q;
      ref_now = {input_ref_b, input_ref_a};
      wd_term[0] = s_q.wd_cnt_a;
      wd_term[1] = s_q.wd_cnt_b;
      rd_take = hsel && hready && htrans == llrm_pkg::HTRANS_NONSEQ && !hwrite;
      wr_take = hsel && hready && htrans == llrm_pkg::HTRANS_NONSEQ && hwrite;
      // gap bits between the two powers are not stored, so they read back as zero
      dwell_wr = {hwdata[llrm_pkg::DWL_Y_LSB +: llrm_pkg::YP_W],
                  (DW-llrm_pkg::XP_W-llrm_pkg::YP_W)'(0), hwdata[llrm_pkg::XP_W-1:0]};
      // offset is sign-extended so negative settings pull the loop earlier
      adj_new = pd_sample + PD_W'(signed'(s_q.phase_offset_constant));
      diff    = PW'(adj_new) - PW'(s_q.adj);
      mag_p   = adj_new[PD_W-1] ? PW'(-PW'(adj_new)) : PW'(adj_new);
      mag_f   = diff[PW-1] ? -diff : diff;
      if (pd_valid) begin
         s_d.adj   = adj_new;
         s_d.ph_ok = ({{(llrm_pkg::THR_W-PW){1'b0}}, mag_p} <= s_q.phase_lock_threshold);
         s_d.fr_ok = ({{(llrm_pkg::THR_W-PW){1'b0}}, mag_f} <= s_q.freq_lock_threshold);
      end
      // watchdogs tick at half the system rate
      s_d.half     = ~s_q.half;
      s_d.ref_last = ref_now;
      for (int i = 0; i < 2; i++) begin
         if (!s_q.loss_en[i]) begin
            s_d.wd[i*llrm_pkg::WD_W +: llrm_pkg::WD_W] = '0;
            s_d.loss[i] = 1'b0;
         end else if (ref_now[i] && !s_q.ref_last[i]) begin
            s_d.wd[i*llrm_pkg::WD_W +: llrm_pkg::WD_W] = '0;
            s_d.loss[i] = 1'b0;
         end else if (s_q.wd[i*llrm_pkg::WD_W +: llrm_pkg::WD_W] >= wd_term[i]) begin
            s_d.loss[i] = 1'b1;
         end else if (s_q.half) begin
            s_d.wd[i*llrm_pkg::WD_W +: llrm_pkg::WD_W] =
               s_q.wd[i*llrm_pkg::WD_W +: llrm_pkg::WD_W] + llrm_pkg::WD_W'(1);
         end
      end
      // status pins: selector 0 off, 1 loss A, 2 loss B, 3 either
      for (int p = 0; p < llrm_pkg::PIN_N; p++) begin
         case (s_q.pin_sel[p*llrm_pkg::SEL_W +: llrm_pkg::SEL_W])
            2'h1:    s_d.pins[p] = s_q.loss[0];
            2'h2:    s_d.pins[p] = s_q.loss[1];
            2'h3:    s_d.pins[p] = |s_q.loss;
            default: s_d.pins[p] = 1'b0;
         endcase
      end
      // irq bits: new loss sets, write-one clears, set wins
      s_d.irq_q = s_q.irq_q;
      s_d.wr_pend = wr_take;
      if (wr_take) begin
         s_d.wr_addr = haddr;
      end
      if (s_q.wr_pend) begin
         case (s_q.wr_addr)
            llrm_pkg::A_OFFSET:  s_d.phase_offset_constant = hwdata[llrm_pkg::OFS_W-1:0];
            llrm_pkg::A_PLK_THR: s_d.phase_lock_threshold = hwdata;
            llrm_pkg::A_FLK_THR: s_d.freq_lock_threshold = hwdata;
            llrm_pkg::A_PLK_DWL: s_d.plk_dwell = dwell_wr;
            llrm_pkg::A_FLK_DWL: s_d.flk_dwell = dwell_wr;
            llrm_pkg::A_WD_A:    s_d.wd_cnt_a = hwdata[llrm_pkg::WD_W-1:0];
            llrm_pkg::A_WD_B:    s_d.wd_cnt_b = hwdata[llrm_pkg::WD_W-1:0];
            llrm_pkg::A_LOSS_CTL: begin
               s_d.loss_en = hwdata[llrm_pkg::CTL_EN_B:llrm_pkg::CTL_EN_A];
               s_d.pin_sel = hwdata[llrm_pkg::CTL_SEL_LSB +: llrm_pkg::PIN_N*llrm_pkg::SEL_W];
            end
            llrm_pkg::A_IRQ:     s_d.irq_q = s_q.irq_q & ~hwdata[1:0];
            default: ;
         endcase
      end
      s_d.irq_q = s_d.irq_q | (s_d.loss & ~s_q.loss);
      s_d.rdata = '0;
      if (rd_take) begin
         case (haddr)
            llrm_pkg::A_OFFSET:  s_d.rdata = {18'h0, s_q.phase_offset_constant};
            llrm_pkg::A_PLK_THR: s_d.rdata = s_q.phase_lock_threshold;
            llrm_pkg::A_FLK_THR: s_d.rdata = s_q.freq_lock_threshold;
            llrm_pkg::A_PLK_DWL: s_d.rdata = {(32-DW)'(0), s_q.plk_dwell};
            llrm_pkg::A_FLK_DWL: s_d.rdata = {(32-DW)'(0), s_q.flk_dwell};
            llrm_pkg::A_WD_A:    s_d.rdata = {16'h0000, s_q.wd_cnt_a};
            llrm_pkg::A_WD_B:    s_d.rdata = {16'h0000, s_q.wd_cnt_b};
            llrm_pkg::A_LOSS_CTL: s_d.rdata = {16'h0000, s_q.pin_sel, 6'h00, s_q.loss_en};
            llrm_pkg::A_STATUS:  s_d.rdata = {28'h0000000, fr_lock, ph_lock, s_q.loss};
            llrm_pkg::A_IRQ:     s_d.rdata = {30'h0, s_q.irq_q};
            default:             s_d.rdata = '0;
         endcase
      end
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_q          <= '0;
         s_q.wd_cnt_a <= llrm_pkg::WD_RST;
         s_q.wd_cnt_b <= llrm_pkg::WD_RST;
      end else begin
         s_q <= s_d;
      end
   end
   llrm_dwell u_phase (
      .hclk     (hclk),
      .hresetn  (hresetn),
      .tick     (loop_tick),
      .cmp_true (s_q.ph_ok),
      .pow_x    (s_q.plk_dwell[llrm_pkg::XP_W-1:0]),
      .pow_y    (s_q.plk_dwell[llrm_pkg::DWL_Y_LSB +: llrm_pkg::YP_W]),
      .locked   (ph_lock)
   );
   llrm_dwell u_freq (
      .hclk     (hclk),
      .hresetn  (hresetn),
      .tick     (loop_tick),
      .cmp_true (s_q.fr_ok),
      .pow_x    (s_q.flk_dwell[llrm_pkg::XP_W-1:0]),
      .pow_y    (s_q.flk_dwell[llrm_pkg::DWL_Y_LSB +: llrm_pkg::YP_W]),
      .locked   (fr_lock)
   );
   assign hrdata           = s_q.rdata;
   assign hreadyout        = 1'b1;
   assign hresp            = 1'b0;
   assign pd_adjusted      = s_q.adj;
   assign phase_locked     = ph_lock;
   assign freq_locked      = fr_lock;
   assign status_pin_group = s_q.pins;
endmodule : llrm_top

//--- tb/llrm_sva.sv
// port checker of the loop lock and reference loss monitor
`timescale 1ns/1ps
module llrm_chk #(
   parameter int PD_W = 24
) (
   input wire logic                   hclk,
   input wire logic                   hresetn,
   input wire logic                   hsel,
   input wire logic [7:0]             haddr,
   input wire logic [1:0]             htrans,
   input wire logic                   hwrite,
   input wire logic                   hready,
   input wire logic [31:0]            hrdata,
   input wire logic                   hreadyout,
   input wire logic                   hresp,
   input wire logic                   loop_tick,
   input wire logic                   pd_valid,
   input wire logic signed [PD_W-1:0] pd_adjusted,
   input wire logic                   phase_locked,
   input wire logic                   freq_locked
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   logic rd_now;
   assign rd_now = hsel && hready && htrans == llrm_pkg::HTRANS_NONSEQ && !hwrite;
   sequence rd_acc;
      hsel && hready && htrans == llrm_pkg::HTRANS_NONSEQ && !hwrite;
   endsequence
   // lock state may only move shortly after a loop tick
   sequence tick_near;
      $past(loop_tick) || $past(loop_tick, 2) || $past(loop_tick, 3);
   endsequence
   ready_const_a: assert property (hreadyout) else $error("hreadyout low");
   resp_okay_a: assert property (!hresp) else $error("error response");
   rdata_idle_a: assert property (hrdata != 32'h0 |-> $past(rd_now))
      else $error("read data outside a read data phase");
   unmapped_zero_a: assert property (rd_acc ##0 haddr > 8'h24 |=> hrdata == 32'h0)
      else $error("unmapped read not zero");
   plock_rise_a: assert property ($rose(phase_locked) |-> tick_near)
      else $error("phase lock rose without tick");
   plock_fall_a: assert property ($fell(phase_locked) |-> tick_near)
      else $error("phase lock fell without tick");
   flock_move_a: assert property ($changed(freq_locked) |-> tick_near)
      else $error("freq lock moved without tick");
   adj_cause_a: assert property ($changed(pd_adjusted) |-> $past(pd_valid) || $past(hsel)
      || $past(hsel, 2)) else $error("adjusted sample moved without cause");
endmodule : llrm_chk
bind llrm_top llrm_chk #(.PD_W(PD_W)) llrm_chk_inst (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
   .hresp(hresp), .loop_tick(loop_tick), .pd_valid(pd_valid), .pd_adjusted(pd_adjusted),
   .phase_locked(phase_locked), .freq_locked(freq_locked)
);

//--- tb/llrm_far_end.sv
// reference clocks and phase detector samples beside the monitor
`timescale 1ns/1ps
module llrm_far_end (
   input  wire logic               hclk,
   input  wire logic               hresetn,
   input  wire logic               run_a,
   input  wire logic               run_b,
   input  wire logic signed [23:0] pd_val,
   output      logic               loop_tick,
   output      logic               pd_valid,
   output      logic signed [23:0] pd_sample,
   output      logic               input_ref_a,
   output      logic               input_ref_b
);
   logic [7:0] cnt_q;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_q <= 8'h00;
         pd_sample <= 24'h000000;
      end else begin
         cnt_q <= cnt_q + 8'h01;
         // sample good only in its tick, scrambled elsewhere
         pd_sample <= (cnt_q[2:0] == 3'h6) ? pd_val : ~pd_sample;
      end
   end
   assign loop_tick = (cnt_q[2:0] == 3'h7);
   assign pd_valid = loop_tick;
   // period of 16 cycles, well under a count of 10; a stopped ref stands low
   assign input_ref_a = run_a & cnt_q[3];
   assign input_ref_b = run_b & cnt_q[3];
endmodule : llrm_far_end

//--- tb/llrm_top_tb.sv
// self-checking bench of the loop lock and reference loss monitor
`timescale 1ns/1ps
module llrm_top_tb;
   logic               hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic               run_a = 1'b1, run_b = 1'b1, rd_ph = 1'b0, pd_chk = 1'b0, pv_d = 1'b0;
   logic [7:0]         haddr = 8'h00;
   logic [1:0]         htrans = 2'h0;
   logic [2:0]         hsize = 3'h2;
   logic [31:0]        hwdata = 32'h0, hrdata;
   logic signed [23:0] pd_val = 24'h0, ps_d = 24'h0, pd_sample, pd_adjusted;
   logic signed [13:0] ofs = 14'h0;
   logic               hreadyout, hresp, loop_tick, pd_valid, input_ref_a, input_ref_b;
   logic               phase_locked, freq_locked;
   logic [3:0]         pins;
   logic [31:0]        exp_q[$];
   int                 bad_count = 0, n_checks = 0, seed = 36, nt = 0, t0, r;
   wire [2:0]          obs = {freq_locked, phase_locked, hreadyout};
   llrm_top llrm_top_inst (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .loop_tick(loop_tick),
      .pd_valid(pd_valid), .pd_sample(pd_sample), .input_ref_a(input_ref_a),
      .input_ref_b(input_ref_b), .pd_adjusted(pd_adjusted), .phase_locked(phase_locked),
      .freq_locked(freq_locked), .status_pin_group(pins));
   llrm_far_end llrm_far_end_inst (
      .hclk(hclk), .hresetn(hresetn), .run_a(run_a), .run_b(run_b), .pd_val(pd_val),
      .loop_tick(loop_tick), .pd_valid(pd_valid), .pd_sample(pd_sample),
      .input_ref_a(input_ref_a), .input_ref_b(input_ref_b));
   initial begin
      forever #2.5 hclk = ~hclk;
   end
   task chk(input logic [31:0] seen, input logic [31:0] expv);
      n_checks++;
      if (seen !== expv) begin
         bad_count++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, expv);
      end
   endtask : chk
   task give_verdict;
      if (bad_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : give_verdict
   // looks on the falling edge so the design's updates have landed
   task wait_sig(input int k, input logic v);
      int i;
      for (i = 0; i < 400; i++) begin
         @(negedge hclk);
         if (obs[k] === v) break;
      end
      if (i == 400) begin
         bad_count++;
         give_verdict();
      end
      @(posedge hclk);
   endtask : wait_sig
   // read: d is the expected word, checked against hrdata by the clocked block below
   task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= llrm_pkg::HTRANS_NONSEQ;
      haddr <= a;
      hwrite <= w;
      wait_sig(0, 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      rd_ph <= !w;
      if (!w) exp_q.push_back(d);
      wait_sig(0, 1'b1);
      rd_ph <= 1'b0;
   endtask : xfer
   always @(posedge hclk) begin
      pv_d <= pd_valid;
      ps_d <= pd_sample;
      if (loop_tick) nt <= nt + 1;
      if (rd_ph) chk(hrdata, exp_q.pop_front());
      if (pd_chk && pv_d) chk({8'h00, pd_adjusted}, {8'h00, 24'(ps_d + ofs)});
   end
   initial begin
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      xfer(0, llrm_pkg::A_WD_A, 32'h0000FFFF);
      xfer(0, llrm_pkg::A_OFFSET, 32'h0);
      xfer(1, 8'h30, 32'hFFFFFFFF);
      xfer(0, 8'h30, 32'h0);
      repeat (4) begin
         pd_chk <= 1'b0;
         r = $random(seed) % 2048;
         ofs <= 14'(r);
         pd_val <= 24'($random(seed));
         xfer(1, llrm_pkg::A_OFFSET, {18'h0, 14'(r)});
         xfer(0, llrm_pkg::A_OFFSET, {18'h0, 14'(r)});
         pd_chk <= 1'b1;
         repeat (20) @(posedge hclk);
      end
      pd_chk <= 1'b0;
      pd_val <= -24'sd60;
      xfer(1, llrm_pkg::A_OFFSET, 32'h0);
      xfer(1, llrm_pkg::A_PLK_DWL, 32'h00000002);
      xfer(1, llrm_pkg::A_FLK_DWL, 32'h00000002);
      xfer(1, llrm_pkg::A_FLK_THR, 32'h00000032);
      xfer(1, llrm_pkg::A_PLK_THR, 32'h00000064);
      t0 = nt;
      wait_sig(1, 1'b1);
      chk(32'(nt - t0 inside {[4:5]}), 32'h1);
      xfer(0, llrm_pkg::A_STATUS, 32'hC);
      chk({31'h0, freq_locked}, 32'h1);
      pd_val <= 24'sd3000;
      t0 = nt;
      wait_sig(1, 1'b0);
      chk(32'(nt - t0 inside {[2:3]}), 32'h1);
      xfer(0, llrm_pkg::A_STATUS, 32'h8);
      xfer(1, llrm_pkg::A_WD_A, 32'h0000000A);
      xfer(1, llrm_pkg::A_WD_B, 32'h0000000A);
      xfer(1, llrm_pkg::A_LOSS_CTL, 32'h00003903);
      repeat (40) @(posedge hclk);
      xfer(0, llrm_pkg::A_STATUS, 32'h8);
      run_a <= 1'b0;
      repeat (40) @(posedge hclk);
      xfer(0, llrm_pkg::A_STATUS, 32'h9);
      chk({28'h0, pins}, 32'h5);
      xfer(0, llrm_pkg::A_IRQ, 32'h1);
      run_a <= 1'b1;
      repeat (40) @(posedge hclk);
      xfer(0, llrm_pkg::A_STATUS, 32'h8);
      chk({28'h0, pins}, 32'h0);
      xfer(0, llrm_pkg::A_IRQ, 32'h1);
      xfer(1, llrm_pkg::A_IRQ, 32'h1);
      xfer(0, llrm_pkg::A_IRQ, 32'h0);
      give_verdict();
   end
endmodule : llrm_top_tb
